// file: inc/sms_pkg.sv
// shared constants and types for the stand-alone mode sequencer
package sms_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned WAKE_MS = 30;
    localparam int unsigned STARTUP_MS = 10;
    localparam int unsigned SOFTSTART_MS = 20;
    localparam int unsigned IDLE_MS = 15;
    localparam int unsigned STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
    localparam int unsigned SOFTSTART_CYC = SOFTSTART_MS * (CLK_HZ / 1000);
    localparam int unsigned IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
    // whole 30 ms wake figure, counted from the waking edge
    localparam int unsigned WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
    // ------------------------------------------------------------
    // duty thresholds in percent, index = level being entered / left
    // ------------------------------------------------------------
    localparam logic [6:0] UP_PCT [8] = '{7'd1, 7'd20, 7'd35, 7'd48,
                                         7'd58, 7'd68, 7'd82, 7'd97};
    // falling: level k drops to k-1 below DN_PCT[k]; level 0 needs 0 %
    localparam logic [6:0] DN_PCT [8] = '{7'd0, 7'd15, 7'd28, 7'd42,
                                         7'd52, 7'd62, 7'd75, 7'd90};
    localparam logic [2:0] LEVEL_RST = 3'h0;
    localparam logic STANDBY_RELEASE_RST = 1'b0;
    localparam logic BOOST_EN_RST = 1'b1;
    localparam logic BRC_OFF_RST = 1'b0;
    // ------------------------------------------------------------
    // operating states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        SMS_STANDBY   = 5'b00001,
        SMS_STARTUP   = 5'b00010,
        SMS_SOFTSTART = 5'b00100,
        SMS_NORMAL    = 5'b01000,
        SMS_RESET     = 5'b10000
    } sms_state_t;
endpackage : sms_pkg

// file: logic/sms_duty_quant.sv
// duty cycle meter and hysteretic 3-bit level quantiser
`timescale 1ns/1ps
module sms_duty_quant #(
    parameter int unsigned CNT_W = 18
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // brightness input, edge strobe and run enable
    input wire logic brc_i,
    input wire logic rise_i,
    input wire logic run_i,
    // results
    output logic [2:0] level_o,
    output logic on_o,
    output logic upd_o
);
    import sms_pkg::*;

    initial begin
        if (CNT_W < 16 || CNT_W > 24) begin
            $error("sms_duty_quant: CNT_W out of range");
        end
    end

    logic [CNT_W-1:0] hi_reg;
    logic [CNT_W-1:0] per_reg;
    logic [CNT_W-1:0] hi_lat_reg;
    logic [CNT_W-1:0] per_lat_reg;
    logic meas_vld_reg;
    logic [2:0] level_reg;
    logic on_reg;
    logic upd_reg;
    logic [2:0] level_next;
    logic on_next;
    logic [CNT_W+6:0] hi_x100;
    logic [7:0] cmp_up;
    logic [7:0] cmp_dn;

    // ------------------------------------------------------------
    // period counters, closed at each rising edge
    // ------------------------------------------------------------
    // high time and period counted in core cycles; saturating
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_i) begin
            hi_reg <= '0;
            per_reg <= '0;
            hi_lat_reg <= '0;
            per_lat_reg <= '0;
            meas_vld_reg <= 1'b0;
        end else if (rise_i) begin
            hi_lat_reg <= hi_reg;
            per_lat_reg <= per_reg;
            meas_vld_reg <= per_reg != '0;
            hi_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
            per_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
            if (!(&per_reg)) per_reg <= per_reg + 1'b1;
            if (brc_i && !(&hi_reg)) hi_reg <= hi_reg + 1'b1;
            meas_vld_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // threshold compare: hi*100 >= pct*per, no divider needed
    // ------------------------------------------------------------
    assign hi_x100 = 7'(100) * hi_lat_reg;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_cmp
            assign cmp_up[g] = hi_x100 >= UP_PCT[g] * per_lat_reg;
            assign cmp_dn[g] = hi_x100 >= DN_PCT[g] * per_lat_reg;
        end
    endgenerate

    // hysteresis: climb on rising set, fall on falling set
    always_comb begin
        level_next = level_reg;
        on_next = on_reg;
        if (!on_reg) begin
            if (cmp_up[0]) begin
                on_next = 1'b1;
                level_next = 3'h0;
            end
        end else if (level_reg != 3'h7 && cmp_up[level_reg + 3'h1]) begin
            level_next = level_reg + 3'h1;
        end else if (level_reg != 3'h0 && !cmp_dn[level_reg]) begin
            level_next = level_reg - 3'h1;
        end else if (level_reg == 3'h0 && hi_lat_reg == '0) begin
            on_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // level register: one step per measured period, so large
    // jumps settle in two periods only for adjacent levels
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_i) begin
            level_reg <= LEVEL_RST;
            on_reg <= 1'b0;
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= meas_vld_reg;
            if (meas_vld_reg) begin
                level_reg <= level_next;
                on_reg <= on_next;
            end
        end
    end

    assign level_o = level_reg;
    assign on_o = on_reg;
    assign upd_o = upd_reg;
endmodule : sms_duty_quant

// file: logic/sms_sequencer.sv
// operating-state sequencer with stand-alone brightness decoding
`timescale 1ns/1ps
module sms_sequencer #(
    parameter int unsigned STARTUP_CYCLES = sms_pkg::STARTUP_CYC,
    parameter int unsigned SOFTSTART_CYCLES = sms_pkg::SOFTSTART_CYC,
    parameter int unsigned WAKE_CYCLES = sms_pkg::WAKE_CYC,
    parameter int unsigned IDLE_CYCLES = sms_pkg::IDLE_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // reset sources
    input wire logic external_reset_n_i,
    input wire logic power_on_reset_i,
    // register bits from the serial port, with write strobes
    input wire logic standby_release_bit_i,
    input wire logic boost_en_i,
    input wire logic boost_en_wr_i,
    input wire logic brc_off_i,
    input wire logic reg_wr_i,
    // brightness input and events
    input wire logic brc_i,
    input wire logic overtemperature_event_i,
    input wire logic nvm_trim_done_i,
    // outputs
    output sms_pkg::sms_state_t state_o,
    output logic reg_clear_o,
    output logic standalone_o,
    output logic nvm_load_o,
    output logic boost_on_o,
    output logic boost_soft_o,
    output logic boost_adaptive_o,
    output logic leds_on_o,
    output logic [2:0] level_o
);
    import sms_pkg::*;

    initial begin
        if (STARTUP_CYCLES + SOFTSTART_CYCLES > WAKE_CYCLES ||
            IDLE_CYCLES < 1 || WAKE_CYCLES > 32'h00ff_ffff) begin
            $error("sms_sequencer: timing parameters inconsistent");
        end
    end

    sms_state_t state_reg;
    sms_state_t state_next;
    logic brc_d_reg;
    logic brc_rise;
    logic int_rst;
    logic sa_reg;
    logic [23:0] tmr_reg;
    logic [23:0] wake_reg;
    logic [23:0] idle_reg;
    logic trim_seen_reg;
    logic wake_done;
    logic idle_out;
    logic [2:0] q_level;
    logic q_on;
    logic leds_reg;
    logic [2:0] level_reg;
    logic boost_prev_reg;

    // ------------------------------------------------------------
    // reset merge and edge detect
    // ------------------------------------------------------------
    assign int_rst = rst_i || !external_reset_n_i || power_on_reset_i;
    assign brc_rise = brc_i && !brc_d_reg && !brc_off_i;

    always_ff @(posedge core_clk_i) begin
        if (int_rst) brc_d_reg <= 1'b0;
        else brc_d_reg <= brc_i;
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    assign wake_done = wake_reg == '0;
    assign idle_out = sa_reg && idle_reg == '0;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SMS_RESET: state_next = SMS_STANDBY;
            SMS_STANDBY: begin
                // register bit or edge starts the power-up path
                if (standby_release_bit_i || brc_rise)
                    state_next = SMS_STARTUP;
            end
            SMS_STARTUP: begin
                // wait counts only once trim values are in
                if (!overtemperature_event_i && trim_seen_reg &&
                    tmr_reg == '0) begin
                    state_next = boost_en_i ? SMS_SOFTSTART : SMS_NORMAL;
                end
            end
            SMS_SOFTSTART: begin
                if (tmr_reg == '0) state_next = SMS_NORMAL;
            end
            SMS_NORMAL: begin
                if (boost_en_wr_i && boost_en_i && !boost_prev_reg)
                    state_next = SMS_SOFTSTART;
            end
            default: state_next = SMS_RESET;
        endcase
        // overtemperature forces start-up from any powered state; the standby return below still wins over it
        if (overtemperature_event_i && state_reg != SMS_STANDBY &&
            state_reg != SMS_RESET) state_next = SMS_STARTUP;
        // idle timeout or, in host mode, release bit low returns to standby
        if (state_reg != SMS_RESET && state_reg != SMS_STANDBY &&
            (idle_out || (!sa_reg && !standby_release_bit_i)))
            state_next = SMS_STANDBY;
    end

    always_ff @(posedge core_clk_i) begin
        if (int_rst) state_reg <= SMS_RESET;
        else state_reg <= state_next;
    end

    // boost state one cycle back: the live output already follows the
    // written bit, so it cannot tell whether the write turned boost on
    always_ff @(posedge core_clk_i) begin
        if (int_rst) boost_prev_reg <= 1'b0;
        else boost_prev_reg <= boost_on_o;
    end

    // ------------------------------------------------------------
    // stand-alone flag: set by the waking edge, cleared at standby
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (int_rst) sa_reg <= 1'b0;
        else if (state_reg == SMS_STANDBY && brc_rise) sa_reg <= 1'b1;
        else if (state_next == SMS_STANDBY) sa_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // state timer, loaded on state entry
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (int_rst) begin
            tmr_reg <= '0;
            trim_seen_reg <= 1'b0;
        end else if (state_next != state_reg) begin
            trim_seen_reg <= 1'b0;
            if (state_next == SMS_STARTUP)
                tmr_reg <= 24'(STARTUP_CYCLES - 1);
            else if (state_next == SMS_SOFTSTART)
                tmr_reg <= 24'(SOFTSTART_CYCLES - 1);
            else tmr_reg <= '0;
        end else if (state_reg == SMS_STARTUP && overtemperature_event_i) begin
            // a hot chip restarts the whole wait once it cools
            trim_seen_reg <= 1'b0;
            tmr_reg <= 24'(STARTUP_CYCLES - 1);
        end else if (state_reg == SMS_STARTUP && !trim_seen_reg) begin
            trim_seen_reg <= nvm_trim_done_i;
        end else if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 24'h1;
        end
    end

    // ------------------------------------------------------------
    // wake delay and idle timeout for stand-alone use
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (int_rst || !sa_reg) begin
            wake_reg <= 24'(WAKE_CYCLES - 1);
            idle_reg <= 24'(IDLE_CYCLES - 1);
        end else begin
            if (!wake_done) wake_reg <= wake_reg - 24'h1;
            // any high level or edge restarts the idle window
            if (brc_i) idle_reg <= 24'(IDLE_CYCLES - 1);
            else if (idle_reg != '0) idle_reg <= idle_reg - 24'h1;
        end
    end

    // ------------------------------------------------------------
    // duty quantiser
    // ------------------------------------------------------------
    sms_duty_quant #(
        .CNT_W(18)
    ) u_quant (
        .core_clk_i(core_clk_i),
        .rst_i(int_rst),
        .brc_i(brc_i),
        .rise_i(brc_rise),
        .run_i(sa_reg),
        .level_o(q_level),
        .on_o(q_on),
        .upd_o()
    );

    // ------------------------------------------------------------
    // led gate: off in soft-start and, in stand-alone, before the wake delay
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (int_rst) begin
            leds_reg <= 1'b0;
            level_reg <= LEVEL_RST;
        end else begin
            // next state, so leds drop on the very edge that leaves normal
            leds_reg <= state_next == SMS_NORMAL &&
                (!sa_reg || (wake_done && q_on));
            level_reg <= q_level;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign state_o = state_reg;
    // registers go to defaults in reset; writes otherwise pass freely
    assign reg_clear_o = state_reg == SMS_RESET;
    assign standalone_o = sa_reg;
    assign nvm_load_o = sa_reg && state_reg == SMS_STARTUP;
    // boost stays off when the enable bit is low
    assign boost_on_o = boost_en_i && (state_reg == SMS_SOFTSTART ||
        state_reg == SMS_NORMAL);
    assign boost_soft_o = state_reg == SMS_SOFTSTART;
    assign boost_adaptive_o = sa_reg || boost_on_o;
    assign leds_on_o = leds_reg;
    assign level_o = level_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    reset_goes_standby_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) state_reg == SMS_RESET |=> state_reg == SMS_STANDBY)
        else $error("reset did not lead to standby");
    wake_edge_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) state_reg == SMS_STANDBY && brc_rise
        |=> state_reg == SMS_STARTUP && sa_reg)
        else $error("brightness edge did not wake");
    soft_leds_off_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) state_reg == SMS_SOFTSTART |-> !leds_on_o)
        else $error("leds lit during soft-start");
    hot_startup_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) overtemperature_event_i &&
        state_reg == SMS_NORMAL && !idle_out &&
        (sa_reg || standby_release_bit_i) |=> state_reg == SMS_STARTUP)
        else $error("overtemperature not honoured");
    boost_off_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) !boost_en_i |-> !boost_on_o)
        else $error("boost on with enable low");
    leds_wait_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) leds_on_o && sa_reg |-> wake_done)
        else $error("leds before wake delay");
    idle_standby_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) idle_out && state_reg != SMS_STANDBY
        |=> state_reg == SMS_STANDBY)
        else $error("idle timeout missed");
    nvm_sa_a: assert property (@(posedge core_clk_i)
        disable iff (int_rst) nvm_load_o |-> sa_reg && state_reg == SMS_STARTUP)
        else $error("nvm load outside stand-alone start-up");
    cv_wake_c: cover property (@(posedge core_clk_i) disable iff (int_rst)
        state_reg == SMS_STANDBY && brc_rise);
    cv_soft_c: cover property (@(posedge core_clk_i) disable iff (int_rst)
        state_reg == SMS_SOFTSTART ##1 state_reg == SMS_NORMAL);
    cv_leds_c: cover property (@(posedge core_clk_i) disable iff (int_rst)
        leds_on_o && level_o == 3'h7);
    cv_wr_stby_c: cover property (@(posedge core_clk_i) disable iff (int_rst)
        reg_wr_i && state_reg == SMS_STANDBY);
endmodule : sms_sequencer

// file: verification/sms_brc_host.sv
// host-side brightness pwm source that drives the sequencer's input
`timescale 1ns/1ps
module sms_brc_host (
    // clock
    input wire logic core_clk_i,
    // pwm setting, period and high time in clock cycles
    input wire logic run_i,
    input wire logic [7:0] period_i,
    input wire logic [7:0] high_i,
    // brightness line
    output logic brc_o
);
    int phase = 0;

    initial brc_o = 1'b0;

    // free-running period counter; the period is scaled down from the
    // khz range so that a full level sweep stays short
    always @(negedge core_clk_i) begin
        if (!run_i) begin
            phase <= 0;
            brc_o <= 1'b0;
        end else begin
            phase <= (phase + 1 >= int'(period_i)) ? 0 : phase + 1;
            brc_o <= (phase < int'(high_i));
        end
    end
endmodule : sms_brc_host

// file: verification/tb_sms_sequencer.sv
// self-checking bench for the stand-alone mode sequencer
`timescale 1ns/1ps
module tb_sms_sequencer;
    import sms_pkg::*;
    // ------------------------------------------------------------
    // scaled timing: one brightness period is PER clock cycles
    // ------------------------------------------------------------
    localparam int PER = 100;
    localparam int WAKE = 80;
    localparam int IDLE = 400;

    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic external_reset_n_i = 1'b1;
    logic power_on_reset_i = 1'b0;
    logic standby_release_bit_i = 1'b0;
    logic boost_en_i = 1'b1;
    logic boost_en_wr_i = 1'b0;
    logic brc_off_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic brc_i;
    logic overtemperature_event_i = 1'b0;
    logic nvm_trim_done_i = 1'b1;
    sms_state_t state_o;
    logic reg_clear_o, standalone_o, nvm_load_o, boost_on_o;
    logic boost_soft_o, boost_adaptive_o, leds_on_o;
    logic [2:0] level_o;
    logic pwm_run = 1'b0;
    logic [7:0] pwm_high = 8'h00;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    sms_sequencer #(.STARTUP_CYCLES(20), .SOFTSTART_CYCLES(30),
        .WAKE_CYCLES(WAKE), .IDLE_CYCLES(IDLE)) sms_sequencer_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .external_reset_n_i(external_reset_n_i),
        .power_on_reset_i(power_on_reset_i),
        .standby_release_bit_i(standby_release_bit_i),
        .boost_en_i(boost_en_i), .boost_en_wr_i(boost_en_wr_i),
        .brc_off_i(brc_off_i), .reg_wr_i(reg_wr_i), .brc_i(brc_i),
        .overtemperature_event_i(overtemperature_event_i),
        .nvm_trim_done_i(nvm_trim_done_i), .state_o(state_o),
        .reg_clear_o(reg_clear_o), .standalone_o(standalone_o),
        .nvm_load_o(nvm_load_o), .boost_on_o(boost_on_o),
        .boost_soft_o(boost_soft_o), .boost_adaptive_o(boost_adaptive_o),
        .leds_on_o(leds_on_o), .level_o(level_o));

    sms_brc_host sms_brc_host_i (.core_clk_i(core_clk_i), .run_i(pwm_run),
        .period_i(8'h64), .high_i(pwm_high), .brc_o(brc_i));

    // ------------------------------------------------------------
    // clock, timeout and shared helpers
    // ------------------------------------------------------------
    initial forever #4 core_clk_i = ~core_clk_i;

    // ceiling well above the roughly 8000 cycles the tests need
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : chk

    // bounded wait for a state, then compare
    task automatic wait_st(input logic [4:0] s, input int lim,
                           input string msg);
        for (int i = 0; i < lim && state_o !== s; i++)
            @(negedge core_clk_i);
        chk(8'(state_o), 8'(s), msg);
    endtask : wait_st

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    // new duty reaches the host on the next cycle, early in a period, then four periods of settling
    task automatic set_duty(input int pct);
        pwm_high <= 8'(pct);
        cyc(4 * PER);
    endtask : set_duty

    task automatic wr_boost(input logic v);
        boost_en_i = v;
        boost_en_wr_i = 1'b1;
        reg_wr_i = 1'b1;
        cyc(1);
        boost_en_wr_i = 1'b0;
        reg_wr_i = 1'b0;
        cyc(1);
    endtask : wr_boost

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int k = 0; k < 3; k++) begin
            rst_i = (k == 0);
            external_reset_n_i = (k != 1);
            power_on_reset_i = (k == 2);
            cyc(1);
            chk(8'(state_o), 8'(SMS_RESET), "reset state");
            chk({leds_on_o, standalone_o, reg_clear_o}, 8'h01, "rst outs");
            rst_i = 1'b0;
            external_reset_n_i = 1'b1;
            power_on_reset_i = 1'b0;
            cyc(1);
            chk(8'(state_o), 8'(SMS_STANDBY), "after reset");
        end
    endtask : t_reset

    task automatic t_refuse();
        brc_off_i = 1'b1;
        pwm_high <= 8'h28;
        pwm_run <= 1'b1;
        cyc(3 * PER);
        chk(8'(state_o), 8'(SMS_STANDBY), "edge while disabled");
        pwm_run <= 1'b0;
        cyc(2);
        brc_off_i = 1'b0;
    endtask : t_refuse

    task automatic t_wake();
        int t0;
        pwm_run <= 1'b1;
        t0 = cycles;
        wait_st(SMS_STARTUP, 4, "wake");
        chk({standalone_o, nvm_load_o}, 8'h03, "stand-alone load");
        wait_st(SMS_SOFTSTART, 40, "soft start");
        chk({boost_soft_o, boost_adaptive_o, leds_on_o}, 8'h06, "soft");
        wait_st(SMS_NORMAL, 40, "normal");
        for (int i = 0; i < 4 * PER && leds_on_o !== 1'b1; i++) cyc(1);
        chk(8'(cycles - t0 >= WAKE), 8'h01, "leds early");
        chk(leds_on_o, 8'h01, "leds late");
    endtask : t_wake

    task automatic t_sweep();
        int up[8] = '{10, 28, 40, 53, 63, 75, 88, 99};
        int dn[7] = '{85, 70, 58, 47, 32, 22, 10};
        for (int i = 0; i < 8; i++) begin
            set_duty(up[i]);
            chk(level_o, 8'(i), "level rising");
        end
        set_duty(93);
        chk(level_o, 8'h07, "upper hysteresis");
        for (int i = 0; i < 7; i++) begin
            set_duty(dn[i]);
            chk(level_o, 8'(6 - i), "level falling");
        end
        set_duty(18);
        chk(level_o, 8'h00, "lower hysteresis");
        chk(leds_on_o, 8'h01, "leds held");
        wr_boost(1'b0);
        chk(boost_on_o, 8'h00, "boost off in stand-alone");
        wr_boost(1'b1);
        wait_st(SMS_SOFTSTART, 4, "boost rewrite");
        wait_st(SMS_NORMAL, 40, "back to normal");
    endtask : t_sweep

    task automatic t_idle();
        pwm_run <= 1'b0;
        cyc(250);
        chk(8'(state_o === SMS_STANDBY), 8'h00, "standby early");
        wait_st(SMS_STANDBY, 300, "idle standby");
        chk(leds_on_o, 8'h00, "leds in standby");
    endtask : t_idle

    task automatic t_host();
        brc_off_i = 1'b1;
        nvm_trim_done_i = 1'b0;
        standby_release_bit_i = 1'b1;
        wait_st(SMS_STARTUP, 4, "release wakes");
        chk(standalone_o, 8'h00, "host mode");
        cyc(40);
        chk(8'(state_o), 8'(SMS_STARTUP), "wait for trim");
        nvm_trim_done_i = 1'b1;
        wait_st(SMS_NORMAL, 80, "host normal");
        chk(boost_on_o, 8'h01, "boost on");
        overtemperature_event_i = 1'b1;
        wait_st(SMS_STARTUP, 4, "overtemp");
        cyc(60);
        chk(8'(state_o), 8'(SMS_STARTUP), "held while hot");
        overtemperature_event_i = 1'b0;
        wait_st(SMS_NORMAL, 80, "recovered");
        standby_release_bit_i = 1'b0;
        wait_st(SMS_STANDBY, 4, "release low");
    endtask : t_host

    // main sequence: reset held for four cycles first
    initial begin
        cyc(4);
        rst_i = 1'b0;
        cyc(1);
        t_reset();
        t_refuse();
        t_wake();
        t_sweep();
        t_idle();
        t_host();
        results();
    end
endmodule : tb_sms_sequencer
